// [src/nvc_params.svh]
// Purpose: Constants for the host-side controller of a byte-wide nonvolatile-shadow SRAM.
// Assumes: 125 MHz clock, 8 ns period; timings are those of the slowest speed grade.
// Notes:   Times are kept in ns, us or ms as named; cycle counts derive from them and round as marked.
`ifndef NVC_PARAMS_SVH
`define NVC_PARAMS_SVH

`define NVC_CLK_PERIOD_NS        8
`define NVC_ADDR_ACCESS_NS       45
`define NVC_CHIP_ACCESS_NS       45
`define NVC_OUT_ACCESS_NS        20
`define NVC_WRITE_PULSE_NS       30
`define NVC_DATA_SETUP_NS        15
`define NVC_FLOAT_NS             15
`define NVC_RECALL_US            550
`define NVC_COPY_MS              10
// Least times round up
`define NVC_CYC_UP(ns) (((ns) + `NVC_CLK_PERIOD_NS - 1) / `NVC_CLK_PERIOD_NS)
`define NVC_READ_CYC   `NVC_CYC_UP(`NVC_CHIP_ACCESS_NS)
`define NVC_WRITE_CYC  `NVC_CYC_UP(`NVC_WRITE_PULSE_NS)
`define NVC_SETUP_CYC  `NVC_CYC_UP(`NVC_DATA_SETUP_NS)
`define NVC_FLOAT_CYC  `NVC_CYC_UP(`NVC_FLOAT_NS)
`define NVC_RECALL_CYC ((`NVC_RECALL_US * 1000) / `NVC_CLK_PERIOD_NS)

`endif

// [src/nvc_pkg.sv]
// Purpose: Types shared by the controller and its pin sequencer.
// Assumes: Constants come from nvc_params.svh.
// Notes:   States are one-hot.
package nvc_pkg;
	localparam int AW = 11;
	localparam int DW = 8;

	typedef enum logic [4:0] {
		NVC_IDLE   = 5'h01,
		NVC_RSETUP = 5'h02,
		NVC_RDWAIT = 5'h04,
		NVC_WDRIVE = 5'h08,
		NVC_WEND   = 5'h10
	} nvc_state_t;

	typedef struct packed {
		nvc_state_t      state;
		logic [15:0]     cnt;
		logic            wr;
		logic [AW-1:0]   addr;
		logic [DW-1:0]   wdata;
	} nvc_seq_t;
endpackage : nvc_pkg

// [src/nvc_req_if.sv]
// Purpose: Request/answer bundle between the controller and its pin sequencer.
// Assumes: One clock; a request is taken when req and rdy are high together.
// Notes:   done pulses one cycle at the end of each access.
`timescale 1ns/10ps
`default_nettype none
interface nvc_req_if;
	logic                     req;
	logic                     wr;
	logic [nvc_pkg::AW-1:0]   addr;
	logic [nvc_pkg::DW-1:0]   wdata;
	logic                     rdy;
	logic                     done;
	logic [nvc_pkg::DW-1:0]   rdata;

	modport ctl (output req, output wr, output addr, output wdata,
		input rdy, input done, input rdata);
	modport seq (input req, input wr, input addr, input wdata,
		output rdy, output done, output rdata);
endinterface : nvc_req_if
`default_nettype wire

// [src/nvc_pin_seq.sv]
// Purpose: Drives one read or write cycle on the asynchronous SRAM pins.
// Assumes: Data lines come in already synchronised by the caller.
// Notes:   Output-enable strobe is held high for the whole write.
`timescale 1ns/10ps
`include "nvc_params.svh"
`default_nettype none
module nvc_pin_seq (
	input  wire logic                   i_clk,
	input  wire logic                   i_rst_n,
	nvc_req_if.seq                      bus,
	input  wire logic [nvc_pkg::DW-1:0] i_dq_sync,
	output logic                        o_chip_on_n,
	output logic                        o_output_on_n,
	output logic                        o_data_load_n,
	output logic [nvc_pkg::AW-1:0]      o_addr,
	output logic [nvc_pkg::DW-1:0]      o_dq_out,
	output logic                        o_dq_oe
);
	import nvc_pkg::*;

	localparam logic [15:0] READ_CYC  = 16'(`NVC_READ_CYC + 3);
	localparam logic [15:0] WRITE_CYC = 16'(`NVC_WRITE_CYC);
	localparam logic [15:0] FLOAT_CYC = 16'(`NVC_FLOAT_CYC);

	nvc_seq_t s_r, s_nxt;
	logic     ce_n_r, oe_n_r, we_n_r, oe_r, done_r;
	logic     ce_n_nxt, oe_n_nxt, we_n_nxt, oe_nxt, done_nxt;
	logic [DW-1:0] rdata_r, rdata_nxt;

	// Sequencer: address first, then strobes, then data sampled or strobes released
	always_comb begin
		s_nxt     = s_r;
		ce_n_nxt  = 1'b1;
		oe_n_nxt  = 1'b1;
		we_n_nxt  = 1'b1;
		oe_nxt    = 1'b0;
		done_nxt  = 1'b0;
		rdata_nxt = rdata_r;
		case (s_r.state)
			NVC_IDLE: begin
				if (bus.req) begin
					s_nxt.addr  = bus.addr;
					s_nxt.wr    = bus.wr;
					s_nxt.wdata = bus.wdata;
					s_nxt.cnt   = 16'h0000;
					// Address settles one cycle before any strobe falls
					s_nxt.state = bus.wr ? NVC_WDRIVE : NVC_RSETUP;
				end
			end
			NVC_RSETUP: begin
				// Load strobe stays high, so this is a read
				ce_n_nxt    = 1'b0;
				oe_n_nxt    = 1'b0;
				s_nxt.state = NVC_RDWAIT;
			end
			NVC_RDWAIT: begin
				ce_n_nxt  = 1'b0;
				oe_n_nxt  = 1'b0;
				s_nxt.cnt = s_r.cnt + 16'h0001;
				// Wait the slower access delay plus three sync stages
				if (s_r.cnt >= READ_CYC) begin
					ce_n_nxt    = 1'b1;
					oe_n_nxt    = 1'b1;
					rdata_nxt   = i_dq_sync;
					done_nxt    = 1'b1;
					s_nxt.state = NVC_IDLE;
				end
			end
			NVC_WDRIVE: begin
				// Data driven from strobe start, so setup is met well before the end
				ce_n_nxt  = 1'b0;
				we_n_nxt  = 1'b0;
				oe_nxt    = 1'b1;
				s_nxt.cnt = s_r.cnt + 16'h0001;
				if (s_r.cnt + 16'h0001 >= WRITE_CYC) begin
					s_nxt.cnt   = 16'h0000;
					s_nxt.state = NVC_WEND;
				end
			end
			NVC_WEND: begin
				// Strobes are up; hold data and address a float time so nothing contends
				oe_nxt    = 1'b1;
				s_nxt.cnt = s_r.cnt + 16'h0001;
				if (s_r.cnt + 16'h0001 >= FLOAT_CYC) begin
					done_nxt    = 1'b1;
					s_nxt.state = NVC_IDLE;
				end
			end
			default: s_nxt.state = NVC_IDLE;
		endcase
		if (!i_rst_n) begin
			s_nxt = '{state: NVC_IDLE, cnt: 16'h0000, wr: 1'b0,
				addr: '0, wdata: '0};
			ce_n_nxt  = 1'b1;
			oe_n_nxt  = 1'b1;
			we_n_nxt  = 1'b1;
			oe_nxt    = 1'b0;
			done_nxt  = 1'b0;
			rdata_nxt = '0;
		end
	end

	// Registered pins
	always_ff @(posedge i_clk) begin
		s_r     <= s_nxt;
		ce_n_r  <= ce_n_nxt;
		oe_n_r  <= oe_n_nxt;
		we_n_r  <= we_n_nxt;
		oe_r    <= oe_nxt;
		done_r  <= done_nxt;
		rdata_r <= rdata_nxt;
	end

	assign o_chip_on_n   = ce_n_r;
	assign o_output_on_n = oe_n_r;
	assign o_data_load_n = we_n_r;
	assign o_addr        = s_r.addr;
	assign o_dq_out      = s_r.wdata;
	assign o_dq_oe       = oe_r;
	assign bus.rdy       = (s_r.state == NVC_IDLE);
	assign bus.done      = done_r;
	assign bus.rdata     = rdata_r;
endmodule : nvc_pin_seq
`default_nettype wire

// [src/nvc_host.sv]
// Purpose: Host controller for a 2K x 8 nonvolatile-shadow SRAM over its async pins.
// Assumes: i_power_good is high while supply is above the trip level.
// Notes:   Accesses are refused until the power-up recall window has passed.
`timescale 1ns/10ps
`include "nvc_params.svh"
`default_nettype none
module nvc_host #(
	parameter int RECALL_CYC = `NVC_RECALL_CYC
) (
	input  wire logic                   i_clk,
	input  wire logic                   i_rst_n,
	input  wire logic                   i_power_good,
	input  wire logic                   i_req,
	input  wire logic                   i_wr,
	input  wire logic [nvc_pkg::AW-1:0] i_addr,
	input  wire logic [nvc_pkg::DW-1:0] i_wdata,
	output logic                        o_ready,
	output logic                        o_done,
	output logic [nvc_pkg::DW-1:0]      o_rdata,
	output logic                        o_chip_on_n,
	output logic                        o_output_on_n,
	output logic                        o_data_load_n,
	output logic [nvc_pkg::AW-1:0]      o_address_lines,
	input  wire logic [nvc_pkg::DW-1:0] i_data_io_lines,
	output logic [nvc_pkg::DW-1:0]      o_data_io_lines,
	output logic                        o_data_io_oe
);
	import nvc_pkg::*;

	typedef struct packed {
		logic [2:0]    pg_sync;
		logic          pg_on;
		logic [DW-1:0] dq_s1;
		logic [DW-1:0] dq_s2;
		logic [DW-1:0] dq_s3;
		logic [23:0]   rcnt;
		logic          avail;
		logic          ready;
	} nvc_top_t;

	nvc_top_t   t_r, t_nxt;
	nvc_req_if  rq ();
	logic       pg_ok;

	// Filtered supply level; a one-stage glitch never flips it
	assign pg_ok = t_r.pg_on;

	// Power gating and data-line synchronisers
	always_comb begin
		t_nxt         = t_r;
		t_nxt.pg_sync = {t_r.pg_sync[1:0], i_power_good};
		t_nxt.dq_s1   = i_data_io_lines;
		t_nxt.dq_s2   = t_r.dq_s1;
		t_nxt.dq_s3   = t_r.dq_s2;
		// A supply change counts only once the second and third stages agree
		if (t_r.pg_sync[1] == t_r.pg_sync[2]) begin
			t_nxt.pg_on = t_r.pg_sync[2];
		end
		if (!pg_ok) begin
			// Low supply: writes blocked and a fresh recall will follow
			t_nxt.rcnt  = 24'h000000;
			t_nxt.avail = 1'b0;
		end else if (!t_r.avail) begin
			// Wait the full recall time with strobes idle
			t_nxt.rcnt = t_r.rcnt + 24'h000001;
			if (t_r.rcnt >= 24'(RECALL_CYC)) begin
				t_nxt.avail = 1'b1;
			end
		end
		t_nxt.ready = t_nxt.avail & rq.rdy & ~(i_req & t_r.ready);
		if (!i_rst_n) begin
			t_nxt = '0;
		end
	end

	always_ff @(posedge i_clk) begin
		t_r <= t_nxt;
	end

	// Request taken only while the memory is usable
	assign rq.req   = i_req & t_r.ready & t_r.avail & pg_ok;
	assign rq.wr    = i_wr;
	assign rq.addr  = i_addr;
	assign rq.wdata = i_wdata;

	nvc_pin_seq u_seq (
		.i_clk         (i_clk),
		.i_rst_n       (i_rst_n),
		.bus           (rq.seq),
		.i_dq_sync     (t_r.dq_s3),
		.o_chip_on_n   (o_chip_on_n),
		.o_output_on_n (o_output_on_n),
		.o_data_load_n (o_data_load_n),
		.o_addr        (o_address_lines),
		.o_dq_out      (o_data_io_lines),
		.o_dq_oe       (o_data_io_oe)
	);

	assign o_ready = t_r.ready;
	assign o_done  = rq.done;
	assign o_rdata = rq.rdata;
endmodule : nvc_host
`default_nettype wire

// [bench/nvc_host_assertions.sv]
// Purpose: Pin-level checks on the host controller.
// Assumes: One clock, sync active-low reset.
// Notes:   Counts are 45 and 30 ns rounded up at 8 ns.
`timescale 1ns/10ps
`default_nettype none
module nvc_host_assertions #(
	parameter int RECALL_CYC = 20
) (
	input  wire logic                   i_clk,
	input  wire logic                   i_rst_n,
	input  wire logic                   i_power_good,
	input  wire logic                   o_ready,
	input  wire logic                   o_chip_on_n,
	input  wire logic                   o_output_on_n,
	input  wire logic                   o_data_load_n,
	input  wire logic [nvc_pkg::AW-1:0] o_address_lines,
	input  wire logic                   o_data_io_oe
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	logic [16:0] up_r;
	wire         wr_on = !o_chip_on_n && !o_data_load_n;
	// Cycles of good supply, so an early ready is caught
	always_ff @(posedge i_clk) begin
		if (!i_rst_n || !i_power_good) up_r <= '0;
		else if (up_r != '1) up_r <= up_r + 1'b1;
	end
	property p_addr; wr_on && $past(wr_on) |-> $stable(o_address_lines); endproperty
	a_addr: assert property (p_addr) else $error("address moved in write");
	property p_drv; wr_on |-> o_data_io_oe && o_output_on_n; endproperty
	a_drv: assert property (p_drv) else $error("write without data or with output on");
	property p_setup; $rose(o_data_load_n) |-> $past(o_data_io_oe, 2); endproperty
	a_setup: assert property (p_setup) else $error("data setup short");
	property p_wlen; $fell(o_data_load_n) |-> (!o_data_load_n)[*4]; endproperty
	a_wlen: assert property (p_wlen) else $error("write pulse short");
	property p_rlen; $fell(o_output_on_n) |-> (!o_output_on_n && !o_chip_on_n)[*6]; endproperty
	a_rlen: assert property (p_rlen) else $error("read strobes short");
	property p_pwr; (!i_power_good)[*6] |-> !o_ready; endproperty
	a_pwr: assert property (p_pwr) else $error("ready with supply low");
	property p_rst; $rose(i_rst_n) |-> o_chip_on_n && o_data_load_n && !o_data_io_oe; endproperty
	a_rst: assert property (p_rst) else $error("strobes active after reset");
	property p_recall; $rose(o_ready) |-> up_r >= RECALL_CYC; endproperty
	a_recall: assert property (p_recall) else $error("ready before recall done");
endmodule : nvc_host_assertions
bind nvc_host nvc_host_assertions #(.RECALL_CYC(RECALL_CYC)) chk_u (.i_clk, .i_rst_n,
	.i_power_good, .o_ready, .o_chip_on_n, .o_output_on_n, .o_data_load_n,
	.o_address_lines, .o_data_io_oe);
`default_nettype wire

// [bench/nvc_mem_model.sv]
// Purpose: Behavioural far-side memory with 2,048 bytes.
// Assumes: No pull-ups on the data lines.
// Notes:   Shadow copy and recall happen at once on the supply edges.
`timescale 1ns/10ps
`default_nettype none
module nvc_mem_model #(
	parameter int ACC_NS = 45
) (
	input  wire logic                   i_chip_on_n,
	input  wire logic                   i_output_on_n,
	input  wire logic                   i_data_load_n,
	input  wire logic                   i_power_good,
	input  wire logic [nvc_pkg::AW-1:0] i_addr,
	input  wire logic [nvc_pkg::DW-1:0] i_host_dq,
	input  wire logic                   i_host_oe,
	output logic      [nvc_pkg::DW-1:0] o_dq
);
	logic [7:0]  mem    [2048];
	logic [7:0]  shadow [2048];
	logic        dirty   = 1'b0;
	logic        pg_last = 1'b0;
	int unsigned acc_gen = 0;
	int unsigned acc_arm = 32'hFFFF_FFFF;
	wire rd = !i_chip_on_n && !i_output_on_n && i_data_load_n;
	wire rd_ok  = rd && (acc_arm == acc_gen);
	wire wr_end = i_chip_on_n | i_data_load_n;
	// Floating lines show the inverse so a stale or early sample never matches
	assign o_dq = i_host_oe ? i_host_dq : (rd_ok ? mem[i_addr] : ~mem[i_addr]);
	// Fixed start pattern, the shadow holding the same bytes
	initial begin
		for (int i = 0; i < 2048; i++) begin
			mem[i]    = 8'(i) ^ 8'h5A;
			shadow[i] = 8'(i) ^ 8'h5A;
		end
	end
	// Any strobe or address change restarts the access time; short gaps never pass early data
	always @(rd or i_addr) begin
		acc_gen = acc_gen + 1;
		if (rd) acc_arm <= #(ACC_NS) acc_gen;
	end
	// Byte taken at the end of a write, refused with supply low
	always @(posedge wr_end) begin
		if (i_power_good) begin
			mem[i_addr] <= i_host_dq;
			dirty = 1'b1;
		end
	end
	// Supply below trip: copy out if written, then lose the SRAM; supply back: recall
	always @(i_power_good) begin
		if (pg_last && i_power_good === 1'b0) begin
			if (dirty) begin
				for (int i = 0; i < 2048; i++) shadow[i] = mem[i];
			end
			for (int i = 0; i < 2048; i++) mem[i] = 8'h00;
			dirty = 1'b0;
		end
		if (!pg_last && i_power_good === 1'b1) begin
			for (int i = 0; i < 2048; i++) mem[i] = shadow[i];
			dirty = 1'b0;
		end
		pg_last = (i_power_good === 1'b1);
	end
endmodule : nvc_mem_model
`default_nettype wire

// [bench/nvc_host_bench.sv]
// Purpose: Self-checking bench for the host controller.
// Assumes: Short recall count; inputs move at falling edges.
// Notes:   Waits are bounded and a run-out ends the run.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin bad_count++; \
	$display("MISMATCH t=%0t got %h exp %h", $time, (a), (b)); end end
module nvc_host_bench;
	import nvc_pkg::*;
	localparam int RC = 20;
	logic          i_clk, i_rst_n, i_power_good, i_req, i_wr, o_ready, o_done;
	logic          o_chip_on_n, o_output_on_n, o_data_load_n, o_data_io_oe;
	logic [AW-1:0] i_addr, o_address_lines;
	logic [DW-1:0] i_wdata, o_rdata, i_data_io_lines, o_data_io_lines;
	int            bad_count = 0;
	int            checks_done = 0;
	nvc_host #(.RECALL_CYC(RC)) dut_u (.i_clk, .i_rst_n, .i_power_good, .i_req, .i_wr,
		.i_addr, .i_wdata, .o_ready, .o_done, .o_rdata, .o_chip_on_n, .o_output_on_n,
		.o_data_load_n, .o_address_lines, .i_data_io_lines, .o_data_io_lines, .o_data_io_oe);
	nvc_mem_model mem_u (.i_chip_on_n(o_chip_on_n), .i_output_on_n(o_output_on_n),
		.i_data_load_n(o_data_load_n), .i_power_good(i_power_good), .i_addr(o_address_lines),
		.i_host_dq(o_data_io_lines), .i_host_oe(o_data_io_oe), .o_dq(i_data_io_lines));
	// Free-running clock
	initial begin
		i_clk = 0;
		forever #4 i_clk = ~i_clk;
	end
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : tally_and_finish
	// One access; request raised only when ready, so it is taken at the next edge
	task automatic access(input logic wr, input logic [AW-1:0] a, input logic [DW-1:0] d);
		int n = 0;
		while (o_ready !== 1'b1 && n < 60) begin
			@(negedge i_clk);
			n++;
		end
		{i_req, i_wr, i_addr, i_wdata} = {1'b1, wr, a, d};
		@(negedge i_clk);
		i_req = 0;
		while (o_done !== 1'b1 && n < 60) begin
			@(negedge i_clk);
			n++;
		end
		if (n >= 60) begin
			bad_count++;
			tally_and_finish();
		end
	endtask : access
	// Supply comes up; ready must wait out the recall window
	task automatic t_power_up;
		int n = 0;
		repeat (10) @(negedge i_clk);
		`CHK(o_ready, 1'b0)
		i_power_good = 1;
		while (o_ready !== 1'b1 && n < RC + 30) begin
			@(negedge i_clk);
			n++;
		end
		`CHK(n > RC, 1'b1)
		`CHK(n < RC + 12, 1'b1)
		if (n >= RC + 30) begin
			bad_count++;
			tally_and_finish();
		end
	endtask : t_power_up
	// Back-to-back writes at both address ends, then readback
	task automatic t_wr_rd;
		logic [AW-1:0] a [3] = '{11'h7FF, 11'h000, 11'h400};
		for (int i = 0; i < 3; i++) access(1'b1, a[i], 8'hA0 + 8'(i));
		for (int i = 0; i < 3; i++) begin
			access(1'b0, a[i], 8'h00);
			`CHK(o_rdata, 8'hA0 + 8'(i))
		end
		access(1'b0, 11'h123, 8'h00);
		`CHK(o_rdata, 8'h23 ^ 8'h5A)
	endtask : t_wr_rd
	// Supply loss: requests are held off until recall passes again
	task automatic t_brownout;
		int n = 0;
		access(1'b1, 11'h055, 8'hC3);
		@(negedge i_clk);
		i_power_good = 0;
		repeat (6) @(negedge i_clk);
		{i_req, i_wr} = 2'h3;
		for (int i = 0; i < 10; i++) begin
			@(negedge i_clk);
			if (o_chip_on_n !== 1'b1) n++;
		end
		i_req = 0;
		`CHK(n, 0)
		t_power_up();
		access(1'b0, 11'h055, 8'h00);
		`CHK(o_rdata, 8'hC3)
		access(1'b0, 11'h7FF, 8'h00);
		`CHK(o_rdata, 8'hA0)
	endtask : t_brownout
	// Main sequence
	initial begin
		{i_rst_n, i_power_good, i_req, i_wr, i_addr, i_wdata} = '0;
		repeat (5) @(negedge i_clk);
		i_rst_n = 1;
		t_power_up();
		t_wr_rd();
		t_brownout();
		tally_and_finish();
	end
endmodule : nvc_host_bench
`default_nettype wire
